// file: hdl/plc_map.svh
`ifndef PLC_MAP_SVH
`define PLC_MAP_SVH

// Configuration space byte offsets, dword aligned.
`define PLC_OFS_LINK_CAPABILITIES 12'h0ec
`define PLC_OFS_LINK_CTRL 12'h0f0

// Nonvolatile configuration word addresses.
`define PLC_NVM_WORD_LAT 8'h18
`define PLC_NVM_WORD_LINK 8'h1a

// Field positions inside nonvolatile word 18h.
`define PLC_NVM_L0S_CC 2:0
`define PLC_NVM_L0S_SEP 5:3
`define PLC_NVM_L1_LAT 8:6

// Field positions inside nonvolatile word 1Ah.
`define PLC_NVM_WIDTH 5:0
`define PLC_NVM_ASPM 9:8

// Capability defaults, in force until the nonvolatile words arrive; the max link speed is fixed and never loaded.
`define PLC_DEF_L1_LAT 3'h6
`define PLC_DEF_L0S_LAT 3'h1
`define PLC_DEF_ASPM_SUP 2'h3
`define PLC_DEF_WIDTH 6'h04
`define PLC_MAX_SPEED 4'h1

// Link capability field positions.
`define PLC_CAP_PORT 31:24
`define PLC_CAP_RSVD 23:18
`define PLC_CAP_L1 17:15
`define PLC_CAP_L0S 14:12
`define PLC_CAP_ASPM 11:10
`define PLC_CAP_WIDTH 9:4
`define PLC_CAP_SPEED 3:0

// Link control field positions.
`define PLC_LC_ASPM 1:0
`define PLC_LC_RCB 3
`define PLC_LC_CC 6
`define PLC_LC_ES 7

// Active state power management codes.
`define PLC_ASPM_OFF 2'h0
`define PLC_ASPM_RSVD 2'h2
`define PLC_ASPM_ALL 2'h3

`endif

// file: hdl/plc_pkg.sv
package plc_pkg;

	typedef struct packed {
		logic [2:0] l1_lat;
		logic [2:0] l0s_cc;
		logic [2:0] l0s_sep;
		logic [1:0] aspm_sup;
		logic [5:0] width;
	} plc_cap_s;

	typedef struct packed {
		logic ext_sync;
		logic common_clk;
		logic rcb;
		logic [1:0] aspm;
	} plc_lctl_s;

endpackage : plc_pkg

// file: hdl/plc_fn_if.sv
`timescale 1ns/100ps
`default_nettype none

interface plc_fn_if;
	logic wr;
	logic [1:0] be;
	logic [15:0] wdata;
	plc_pkg::plc_lctl_s ctl;

	modport func(input wr, input be, input wdata, output ctl);
	modport bank(output wr, output be, output wdata, input ctl);
endinterface : plc_fn_if

`default_nettype wire

// file: hdl/plc_func_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "plc_map.svh"

module plc_func_ctrl
	import plc_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	plc_fn_if.func fn
);

	plc_lctl_s s_q;
	plc_lctl_s s_d;

	// Only the low byte holds writable bits; link disable, retrain and the
	// reserved bits have no storage, so writes to them vanish.
	always_comb begin
		s_d = s_q;
		if (fn.wr && fn.be[0]) begin
			// [RULE_12] ASPM control write
			s_d.aspm = fn.wdata[`PLC_LC_ASPM];
			// [RULE_15] RCB bit write
			s_d.rcb = fn.wdata[`PLC_LC_RCB];
			// [RULE_10] common clock write
			s_d.common_clk = fn.wdata[`PLC_LC_CC];
			// [RULE_09] extended sync write
			s_d.ext_sync = fn.wdata[`PLC_LC_ES];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign fn.ctl = s_q;

endmodule : plc_func_ctrl

`default_nettype wire

// file: hdl/plc_nvm_load.sv
`timescale 1ns/100ps
`default_nettype none
`include "plc_map.svh"

module plc_nvm_load
	import plc_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic nvm_valid,
	input wire logic [7:0] nvm_addr,
	input wire logic [15:0] nvm_data,
	output plc_cap_s cap
);

	localparam plc_cap_s CAP_RST = '{
		l1_lat: `PLC_DEF_L1_LAT,
		l0s_cc: `PLC_DEF_L0S_LAT,
		l0s_sep: `PLC_DEF_L0S_LAT,
		aspm_sup: `PLC_DEF_ASPM_SUP,
		width: `PLC_DEF_WIDTH
	};

	plc_cap_s s_q;
	plc_cap_s s_d;

	always_comb begin
		s_d = s_q;
		if (nvm_valid && nvm_addr == `PLC_NVM_WORD_LAT) begin
			// [RULE_02] L1 latency load
			s_d.l1_lat = nvm_data[`PLC_NVM_L1_LAT];
			// [RULE_04] both L0s latencies
			s_d.l0s_cc = nvm_data[`PLC_NVM_L0S_CC];
			s_d.l0s_sep = nvm_data[`PLC_NVM_L0S_SEP];
		end
		if (nvm_valid && nvm_addr == `PLC_NVM_WORD_LINK) begin
			// [RULE_05] ASPM support load
			s_d.aspm_sup = nvm_data[`PLC_NVM_ASPM];
			// [RULE_06] max width load
			s_d.width = nvm_data[`PLC_NVM_WIDTH];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			s_q <= CAP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign cap = s_q;

endmodule : plc_nvm_load

`default_nettype wire

// file: hdl/plc_link_capabilities_bank.sv
`timescale 1ns/100ps
`default_nettype none
`include "plc_map.svh"

// Behaviour
// [RULE_01] Port number, bits 31:24, is captured from link training.
// [RULE_02] L1 exit latency code comes from nonvolatile word 18h, default 110b.
// [RULE_03] L0s exit latency code reported, default 001b, 111b reserved.
// [RULE_04] L0s code from word bits 2:0 common clock, 5:3 separate clock.
// [RULE_05] ASPM support code loaded from nonvolatile word 1Ah.
// [RULE_06] Max link width loaded from nonvolatile, default four lanes.
// [RULE_07] Max link speed reads fixed 0001b.
// [RULE_08] Each function owns its own link control register at F0h.
// [RULE_09] Extended sync bit 7 asks for long FTS plus TS1 on L0s exit.
// [RULE_10] Bit 6 marks common clock and selects the reported L0s latency.
// [RULE_11] Link disable bit 4 and retrain bit 5 read zero always.
// [RULE_12] Writable ASPM control: 00 off, 01 L0s, 11 L0s and L1.
// [RULE_13] Link ASPM follows the most restrictive function setting.
// [RULE_14] Reserved capability and control bits read zero.
// [RULE_15] Read completion boundary bit 3 is writable, resets to zero.
// [RULE_16] Writes to read-only and loaded fields leave them unchanged.
module plc_link_capabilities_bank
	import plc_pkg::*;
#(
	parameter int NUM_FUNC = 2,
	parameter int FUNC_W = (NUM_FUNC > 1) ? $clog2(NUM_FUNC) : 1
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic cfg_req,
	input wire logic cfg_we,
	input wire logic [FUNC_W-1:0] cfg_func,
	input wire logic [11:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire logic nvm_valid,
	input wire logic [7:0] nvm_addr,
	input wire logic [15:0] nvm_data,
	input wire logic train_port_valid,
	input wire logic [7:0] train_port_num,
	output logic [1:0] link_aspm_en,
	output logic link_ext_sync,
	output logic [NUM_FUNC-1:0] fn_common_clk,
	output logic [NUM_FUNC-1:0] fn_rcb
);

	localparam logic [11:0] OFS_CAP = `PLC_OFS_LINK_CAPABILITIES;
	localparam logic [11:0] OFS_CTRL = `PLC_OFS_LINK_CTRL;

	typedef struct packed {
		logic [7:0] port_num;
		logic [31:0] rdata;
		logic ack;
		logic [1:0] aspm_eff;
		logic ext_sync;
		logic [NUM_FUNC-1:0] cc;
		logic [NUM_FUNC-1:0] rcb;
	} plc_bank_s;

	plc_bank_s s_q;
	plc_bank_s s_d;
	plc_cap_s cap;
	plc_lctl_s ctl_a [NUM_FUNC];
	logic func_ok;
	logic hit_cap;
	logic hit_ctrl;

	assign func_ok = 32'(cfg_func) < NUM_FUNC;
	assign hit_cap = cfg_addr[11:2] == OFS_CAP[11:2];
	assign hit_ctrl = cfg_addr[11:2] == OFS_CTRL[11:2];

	plc_nvm_load u_load (
		.clock(clock),
		.srst(srst),
		.nvm_valid(nvm_valid),
		.nvm_addr(nvm_addr),
		.nvm_data(nvm_data),
		.cap(cap)
	);

	plc_fn_if fn_if [NUM_FUNC] ();

	for (genvar g = 0; g < NUM_FUNC; g++) begin : g_func
		// [RULE_08] per-function write strobe
		assign fn_if[g].wr = cfg_req && cfg_we && hit_ctrl && func_ok &&
			cfg_func == FUNC_W'(g);
		assign fn_if[g].be = cfg_be[1:0];
		assign fn_if[g].wdata = cfg_wdata[15:0];
		assign ctl_a[g] = fn_if[g].ctl;

		plc_func_ctrl u_func (
			.clock(clock),
			.srst(srst),
			.fn(fn_if[g].func)
		);
	end

	// Reads return the accessed function's view; the capability word is
	// shared but its L0s field follows that function's clocking choice.
	always_comb begin
		plc_lctl_s sel;
		logic [1:0] a;
		sel = '0;
		a = '0;
		s_d = s_q;
		s_d.ack = cfg_req;
		if (train_port_valid) begin
			// [RULE_01] port number capture
			s_d.port_num = train_port_num;
		end
		for (int i = 0; i < NUM_FUNC; i++) begin
			if (func_ok && cfg_func == FUNC_W'(i)) begin
				sel = ctl_a[i];
			end
		end
		if (cfg_req && !cfg_we) begin
			// [RULE_14] reserved and unmapped read zero
			s_d.rdata = '0;
			if (func_ok && hit_cap) begin
				s_d.rdata[`PLC_CAP_PORT] = s_q.port_num;
				s_d.rdata[`PLC_CAP_L1] = cap.l1_lat;
				// [RULE_03] L0s code reported
				// [RULE_10] L0s latency select
				s_d.rdata[`PLC_CAP_L0S] = sel.common_clk ?
					cap.l0s_cc : cap.l0s_sep;
				s_d.rdata[`PLC_CAP_ASPM] = cap.aspm_sup;
				s_d.rdata[`PLC_CAP_WIDTH] = cap.width;
				// [RULE_07] fixed link speed
				s_d.rdata[`PLC_CAP_SPEED] = `PLC_MAX_SPEED;
			end
			if (func_ok && hit_ctrl) begin
				// [RULE_11] disable and retrain read zero
				s_d.rdata[`PLC_LC_ASPM] = sel.aspm;
				s_d.rdata[`PLC_LC_RCB] = sel.rcb;
				s_d.rdata[`PLC_LC_CC] = sel.common_clk;
				s_d.rdata[`PLC_LC_ES] = sel.ext_sync;
			end
		end
		// [RULE_13] most restrictive ASPM
		s_d.aspm_eff = cap.aspm_sup;
		s_d.ext_sync = 1'b0;
		for (int i = 0; i < NUM_FUNC; i++) begin
			a = ctl_a[i].aspm;
			// [RULE_12] reserved code acts as off
			if (a == `PLC_ASPM_RSVD) begin
				a = `PLC_ASPM_OFF;
			end
			s_d.aspm_eff = s_d.aspm_eff & a;
			// [RULE_09] extended sync request
			s_d.ext_sync = s_d.ext_sync | ctl_a[i].ext_sync;
			s_d.cc[i] = ctl_a[i].common_clk;
			s_d.rcb[i] = ctl_a[i].rcb;
		end
		if (s_d.aspm_eff == `PLC_ASPM_RSVD) begin
			s_d.aspm_eff = `PLC_ASPM_OFF;
		end
	end

	// [RULE_16] capability has no write path
	always_ff @(posedge clock) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cfg_rdata = s_q.rdata;
	assign cfg_ack = s_q.ack;
	assign link_aspm_en = s_q.aspm_eff;
	assign link_ext_sync = s_q.ext_sync;
	assign fn_common_clk = s_q.cc;
	assign fn_rcb = s_q.rcb;

endmodule : plc_link_capabilities_bank

`default_nettype wire

// file: testbench/plc_link_capabilities_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "plc_map.svh"

module plc_link_capabilities_chk #(
	parameter int NUM_FUNC = 2,
	parameter int FUNC_W = 1
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic cfg_req,
	input wire logic cfg_we,
	input wire logic [FUNC_W-1:0] cfg_func,
	input wire logic [11:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ack,
	input wire logic [1:0] link_aspm_en,
	input wire logic [NUM_FUNC-1:0] fn_common_clk,
	input wire logic [NUM_FUNC-1:0] fn_rcb
);
	logic rd_q, cap_q, ctl_q, wr_q, rcb_q, cc_q, ok;
	logic [FUNC_W-1:0] f_q;
	logic [11:0] a;
	assign a = {cfg_addr[11:2], 2'b00};
	assign ok = cfg_req && !srst && cfg_func < NUM_FUNC;
	always_ff @(posedge clock) begin
		rd_q <= cfg_req && !cfg_we && !srst;
		cap_q <= ok && !cfg_we && a == `PLC_OFS_LINK_CAPABILITIES;
		ctl_q <= ok && !cfg_we && a == `PLC_OFS_LINK_CTRL;
		wr_q <= ok && cfg_we && cfg_be[0] && a == `PLC_OFS_LINK_CTRL;
		f_q <= cfg_func;
		rcb_q <= cfg_wdata[3];
		cc_q <= cfg_wdata[6];
	end

	default clocking @(posedge clock);
	endclocking
	default disable iff (srst);

	a_ack_one_cycle: assert property (cfg_ack == $past(cfg_req))
		else $error("ack late or missing");
	a_speed_fixed: assert property (cap_q |-> cfg_rdata[3:0] == 4'h1)
		else $error("speed code wrong");
	a_cap_rsvd_zero: assert property (cap_q |-> cfg_rdata[23:18] == 6'h0)
		else $error("cap reserved bits set");
	a_ctl_fixed_zero: assert property (ctl_q |-> cfg_rdata[31:8] == 24'h0
		&& cfg_rdata[5:4] == 2'h0 && !cfg_rdata[2])
		else $error("ctl fixed bits set");
	// Fn outputs change at the first edge after the write edge, so a
	// back-to-back write to the same function cannot mask this one.
	a_rcb_follows: assert property (wr_q |-> ##1
		fn_rcb[$past(f_q)] == $past(rcb_q))
		else $error("rcb output wrong");
	a_cc_follows: assert property (wr_q |-> ##1
		fn_common_clk[$past(f_q)] == $past(cc_q))
		else $error("common clock output wrong");
	a_rdata_holds: assert property (!rd_q && !$past(srst) |-> $stable(cfg_rdata))
		else $error("read data moved");
	a_aspm_no_rsvd: assert property (link_aspm_en != 2'h2)
		else $error("link aspm reserved");
endmodule : plc_link_capabilities_chk

bind plc_link_capabilities_bank plc_link_capabilities_chk #(.NUM_FUNC(NUM_FUNC), .FUNC_W(FUNC_W))
	plc_link_capabilities_chk_i (.clock, .srst, .cfg_req, .cfg_we, .cfg_func, .cfg_addr,
	.cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .link_aspm_en, .fn_common_clk,
	.fn_rcb);
`default_nettype wire

// file: testbench/plc_peer_model.sv
`timescale 1ns/100ps
`default_nettype none

module plc_peer_model (
	input wire logic clock,
	output logic nvm_valid,
	output logic [7:0] nvm_addr,
	output logic [15:0] nvm_data,
	output logic train_port_valid,
	output logic [7:0] train_port_num
);
	initial begin
		nvm_valid = 1'b0;
		nvm_addr = 8'h0;
		nvm_data = 16'h0;
		train_port_valid = 1'b0;
		train_port_num = 8'h0;
	end

	// Released lines go inverted so a stale value can never look right.
	task send_word(input logic [7:0] a, input logic [15:0] d);
		@(negedge clock);
		nvm_valid = 1'b1;
		nvm_addr = a;
		nvm_data = d;
		@(negedge clock);
		nvm_valid = 1'b0;
		nvm_addr = ~a;
		nvm_data = ~d;
	endtask : send_word

	task send_port(input logic [7:0] p);
		@(negedge clock);
		train_port_valid = 1'b1;
		train_port_num = p;
		@(negedge clock);
		train_port_valid = 1'b0;
		train_port_num = ~p;
	endtask : send_port
endmodule : plc_peer_model
`default_nettype wire

// file: testbench/pcie_link_capabilities_control_test.sv
`timescale 1ns/100ps
`default_nettype none

module pcie_link_capabilities_control_test;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic cfg_req = 1'b0;
	logic cfg_we = 1'b0;
	logic [0:0] cfg_func = 1'b0;
	logic [11:0] cfg_addr = 12'h0;
	logic [3:0] cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0;
	logic [31:0] cfg_rdata, rd;
	logic cfg_ack, link_ext_sync, nvm_valid, train_port_valid;
	logic [7:0] nvm_addr, train_port_num;
	logic [15:0] nvm_data;
	logic [1:0] link_aspm_en, fn_common_clk, fn_rcb;
	int failures = 0;
	int n_compared = 0;

	always #10 clock = ~clock;

	plc_link_capabilities_bank plc_link_capabilities_bank_i (.clock, .srst, .cfg_req, .cfg_we,
		.cfg_func, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack,
		.nvm_valid, .nvm_addr, .nvm_data, .train_port_valid, .train_port_num,
		.link_aspm_en, .link_ext_sync, .fn_common_clk, .fn_rcb);
	plc_peer_model plc_peer_model_i (.clock, .nvm_valid, .nvm_addr, .nvm_data,
		.train_port_valid, .train_port_num);

	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	task acc(input logic we, input logic f, input logic [11:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(negedge clock);
		cfg_req = 1'b1;
		cfg_we = we;
		cfg_func = f;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		@(negedge clock);
		cfg_req = 1'b0;
		rd = cfg_rdata;
		chk("ack", 32'(cfg_ack), 32'h1);
	endtask : acc

	task t_defaults();
		acc(1'b0, 1'b0, 12'h0ec, 4'h0, 32'h0);
		chk("cap", rd, {8'h0, 6'h0, 3'h6, 3'h1, 2'h3, 6'h04, 4'h1});
		acc(1'b0, 1'b1, 12'h0f0, 4'h0, 32'h0);
		chk("ctl", rd, 32'h0);
	endtask : t_defaults

	task t_ctl();
		acc(1'b1, 1'b1, 12'h0f0, 4'hf, 32'hffff_ffff);
		acc(1'b1, 1'b0, 12'h0f0, 4'he, 32'hffff_ffff);
		acc(1'b1, 1'b0, 12'h0ec, 4'hf, 32'hffff_ffff);
		acc(1'b0, 1'b1, 12'h0f0, 4'h0, 32'h0);
		chk("ctl1", rd, 32'h0000_00cb);
		acc(1'b0, 1'b0, 12'h0f0, 4'h0, 32'h0);
		chk("ctl0", rd, 32'h0);
		acc(1'b0, 1'b0, 12'h0ec, 4'h0, 32'h0);
		chk("cap", rd, {8'h0, 6'h0, 3'h6, 3'h1, 2'h3, 6'h04, 4'h1});
		acc(1'b0, 1'b0, 12'h100, 4'h0, 32'h0);
		chk("unmapped", rd, 32'h0);
		chk("outs", 32'({link_ext_sync, fn_common_clk, fn_rcb}), 32'h1a);
	endtask : t_ctl

	task t_aspm();
		logic [1:0] e;
		acc(1'b1, 1'b1, 12'h0f0, 4'h1, 32'h1);
		for (int c = 0; c < 4; c++) begin
			acc(1'b1, 1'b0, 12'h0f0, 4'h1, 32'(c));
			e = (c == 2) ? 2'h0 : 2'(c & 1);
			repeat (2) @(negedge clock);
			chk("aspm", 32'(link_aspm_en), 32'(e));
			acc(1'b0, 1'b0, 12'h0f0, 4'h0, 32'h0);
			chk("aspm ctl", rd, 32'(c));
		end
		chk("outs a", 32'({link_ext_sync, fn_common_clk, fn_rcb}), 32'h0);
		acc(1'b1, 1'b1, 12'h0f0, 4'h1, 32'h3);
		repeat (2) @(negedge clock);
		chk("aspm all", 32'(link_aspm_en), 32'h3);
	endtask : t_aspm

	task t_nvm();
		plc_peer_model_i.send_word(8'h18, 16'h0162);
		plc_peer_model_i.send_word(8'h1a, 16'h0102);
		plc_peer_model_i.send_word(8'h19, 16'hffff);
		plc_peer_model_i.send_port(8'h5a);
		chk("aspm sup", 32'(link_aspm_en), 32'h1);
		acc(1'b0, 1'b0, 12'h0ec, 4'h0, 32'h0);
		chk("cap sep", rd, {8'h5a, 6'h0, 3'h5, 3'h4, 2'h1, 6'h02, 4'h1});
		acc(1'b1, 1'b0, 12'h0f0, 4'h1, 32'h40);
		acc(1'b0, 1'b0, 12'h0ec, 4'h0, 32'h0);
		chk("cap cc", rd, {8'h5a, 6'h0, 3'h5, 3'h2, 2'h1, 6'h02, 4'h1});
		chk("outs n", 32'({link_ext_sync, fn_common_clk, fn_rcb}), 32'h4);
	endtask : t_nvm

	task t_reset();
		@(negedge clock);
		srst = 1'b1;
		repeat (2) @(negedge clock);
		srst = 1'b0;
		acc(1'b0, 1'b0, 12'h0ec, 4'h0, 32'h0);
		chk("cap rst", rd, {8'h0, 6'h0, 3'h6, 3'h1, 2'h3, 6'h04, 4'h1});
		acc(1'b0, 1'b0, 12'h0f0, 4'h0, 32'h0);
		chk("ctl rst", rd, 32'h0);
		chk("aspm rst", 32'(link_aspm_en), 32'h0);
		chk("outs r", 32'({link_ext_sync, fn_common_clk, fn_rcb}), 32'h0);
	endtask : t_reset

	task wrap_up();
		$display("compared %0d wrong %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (4) @(negedge clock);
		srst = 1'b0;
		t_defaults();
		t_ctl();
		t_aspm();
		t_nvm();
		t_reset();
		wrap_up();
	end
endmodule : pcie_link_capabilities_control_test
`default_nettype wire
